// *** inc/dcgv_pkg.sv ***
/*
  Shared constants and types for the playback channel gain block:
  register addresses, reset values, field positions and gain tables.
  Assumes one clock domain and a byte-wide register port.
*/
`default_nettype none

package dcgv_pkg;

  localparam int unsigned SAMPLE_W  = 24;  // audio sample width
  localparam int unsigned GAIN_FRAC = 14;  // gain tables are unsigned Q2.14

  // register map
  localparam logic [7:0] TRIM_ADDR  = 8'h68;  // chan1a_fine_trim_cfg
  localparam logic [7:0] VOL_ADDR   = 8'h69;  // chan1b_volume_cfg
  localparam logic [7:0] TRIM_RESET = 8'h80;
  localparam logic [7:0] VOL_RESET  = 8'hC9;
  localparam int unsigned TRIM_LSB  = 4;      // trim field is bits 7..4
  localparam logic [3:0] RSVD_VALUE = 4'h0;   // low nibble of trim register

  // volume decode: code + bias splits into 12 half-dB steps per octave
  localparam logic [7:0] VOL_MUTE   = 8'h00;
  localparam logic [8:0] VOL_BIAS   = 9'h01B;  // 27 = 228 - 201
  localparam logic [8:0] VOL_STEPS  = 9'h00C;  // 12 half-dB steps
  localparam logic [5:0] VOL_OCT0   = 6'h13;   // octave index of unity

  // pipeline depth from sample in to sample out
  localparam int unsigned LATENCY   = 2;

  typedef logic [15:0] dcgv_gain_type;

  // fine trim, code 0 = -0.8 dB ... 8 = 0 dB ... 15 = +0.7 dB
  localparam dcgv_gain_type TRIM_TABLE [16] = '{
    16'h3A5F, 16'h3B0B, 16'h3BBB, 16'h3C6C,
    16'h3D1F, 16'h3DD4, 16'h3E8B, 16'h3F44,
    16'h4000, 16'h40BE, 16'h417E, 16'h4240,
    16'h4304, 16'h43CB, 16'h4494, 16'h455F
  };

  // mantissa of one octave in half-dB steps, 0 dB .. +5.5 dB
  localparam dcgv_gain_type VOL_TABLE [12] = '{
    16'h4000, 16'h43CB, 16'h47CF, 16'h4C10,
    16'h5092, 16'h5558, 16'h5A67, 16'h5FC2,
    16'h656F, 16'h6B72, 16'h71CF, 16'h788E
  };

  typedef struct packed {
    logic       wr;     // write strobe, one cycle
    logic       rd;     // read strobe, one cycle
    logic [7:0] addr;   // register address
    logic [7:0] wdata;  // write data
  } dcgv_reg_req_type;

  typedef struct packed {
    logic                        valid;  // one sample pair
    logic signed [SAMPLE_W-1:0]  ch1a;   // channel 1A sample
    logic signed [SAMPLE_W-1:0]  ch1b;   // channel 1B sample
  } dcgv_pair_type;

endpackage : dcgv_pkg

`default_nettype wire

// *** logic/dcgv_top.sv ***
/*
  Playback gain stage for channels 1A and 1B: fine trim on 1A, digital
  volume with mute on 1B, both reached through the byte register port.
  Assumes register port and sample stream come from logic on MCLK_I.
*/
// How it works
// R1: channel 1A has a 4-bit fine trim in bits 7..4, applied to samples.
// R2: trim code 0 is -0.8 dB, each code adds 0.1 dB.
// R3: trim code 8 is unity, code 15 is the +0.7 dB maximum.
// R4: low nibble of trim register reads zero; host writes only zero there.
// R5: channel 1B has an 8-bit volume byte; code 0 mutes the channel.
// R6: volume code 1 is -100 dB, each code adds 0.5 dB.
// R7: volume code 201 is unity, 202 is +0.5 dB.
// R8: volume code 254 is +26.5 dB, 255 is the +27 dB maximum.
// R9: volume register sits at 0x69 and resets to 0xC9.
// R10: trim register sits at 0x68 and resets to 0x80.
// R11: samples are scaled by the gain and saturate instead of wrapping.
`timescale 1ns/1ps
`default_nettype none

module dcgv_top (
  input  wire logic                      MCLK_I,       // 100 MHz clock
  input  wire logic                      RST_N_I,      // async reset, low
  input  wire dcgv_pkg::dcgv_reg_req_type REG_REQ_I,   // register access
  output logic [7:0]                     REG_RDATA_O,  // read data, flop
  input  wire dcgv_pkg::dcgv_pair_type   SAMPLE_I,     // samples in
  output var dcgv_pkg::dcgv_pair_type    SAMPLE_O      // scaled samples
);

  localparam int unsigned SW = dcgv_pkg::SAMPLE_W;
  localparam int unsigned PW = SW + 17;   // sample times signed gain
  localparam int unsigned XW = 48;        // headroom for octave shifts

  logic [3:0]        trim_q;
  logic [7:0]        vol_q;
  logic [8:0]        vol_m;
  logic [5:0]        vol_oct;
  logic [3:0]        vol_rem;
  logic signed [5:0] vol_exp;
  logic signed [PW-1:0] prod_a_q;
  logic signed [PW-1:0] prod_b_q;
  logic signed [5:0]    exp_q;
  logic                 valid_q;
  logic signed [XW-1:0] scaled_a;
  logic signed [XW-1:0] scaled_b;
  logic signed [XW-1:0] shifted_b;

  // clamp a wide value to the sample range
  function automatic logic signed [SW-1:0] sat_sample(
    input logic signed [XW-1:0] v
  );
    logic signed [XW-1:0] hi;
    logic signed [XW-1:0] lo;
    hi = XW'(signed'({1'b0, {(SW-1){1'b1}}}));
    lo = -hi - XW'(1);
    if (v > hi) begin
      sat_sample = hi[SW-1:0];
    end else if (v < lo) begin
      sat_sample = lo[SW-1:0];
    end else begin
      sat_sample = v[SW-1:0];
    end
  endfunction : sat_sample

  // register writes; reserved trim bits are simply not stored
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      trim_q <= dcgv_pkg::TRIM_RESET[7:dcgv_pkg::TRIM_LSB];  // R10
      vol_q  <= dcgv_pkg::VOL_RESET;                         // R9
    end else if (REG_REQ_I.wr) begin
      if (REG_REQ_I.addr == dcgv_pkg::TRIM_ADDR) begin
        trim_q <= REG_REQ_I.wdata[7:dcgv_pkg::TRIM_LSB];     // R1
      end
      if (REG_REQ_I.addr == dcgv_pkg::VOL_ADDR) begin
        vol_q <= REG_REQ_I.wdata;                            // R5
      end
    end
  end

  // register reads, answered one cycle after the strobe
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (REG_REQ_I.rd) begin
      case (REG_REQ_I.addr)
        dcgv_pkg::TRIM_ADDR: begin
          REG_RDATA_O <= {trim_q, dcgv_pkg::RSVD_VALUE};  // R4
        end
        dcgv_pkg::VOL_ADDR:  REG_RDATA_O <= vol_q;
        default:             REG_RDATA_O <= 8'h00;  // unmapped reads zero
      endcase
    end
  end

  // volume code to octave and half-dB remainder
  // 6 dB is taken as one binary octave, so deep cuts drift by about
  // 0.02 dB per octave; traded for a 12-entry table instead of 255
  always_comb begin
    vol_m   = {1'b0, vol_q} + dcgv_pkg::VOL_BIAS;             // R6
    vol_oct = 6'(vol_m / dcgv_pkg::VOL_STEPS);
    vol_rem = 4'(vol_m % dcgv_pkg::VOL_STEPS);
    vol_exp = signed'(vol_oct - dcgv_pkg::VOL_OCT0);          // R7 R8
  end

  // stage one: multiply by the table gain
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      prod_a_q <= '0;
      prod_b_q <= '0;
      exp_q    <= '0;
      valid_q  <= 1'b0;
    end else begin
      valid_q  <= SAMPLE_I.valid;
      prod_a_q <= SAMPLE_I.ch1a *
                  signed'({1'b0, dcgv_pkg::TRIM_TABLE[trim_q]}); // R2 R3
      if (vol_q == dcgv_pkg::VOL_MUTE) begin
        prod_b_q <= '0;                                        // R5
      end else begin
        prod_b_q <= SAMPLE_I.ch1b *
                    signed'({1'b0, dcgv_pkg::VOL_TABLE[vol_rem]}); // R6
      end
      exp_q <= vol_exp;
    end
  end

  // stage two inputs: drop the gain fraction, then apply the octave
  always_comb begin
    scaled_a = XW'(prod_a_q >>> dcgv_pkg::GAIN_FRAC);
    scaled_b = XW'(prod_b_q >>> dcgv_pkg::GAIN_FRAC);
    if (exp_q >= 0) begin
      shifted_b = scaled_b <<< exp_q;                          // R8
    end else begin
      shifted_b = scaled_b >>> (-exp_q);                       // R6
    end
  end

  // stage two: clamp so boost never wraps around full scale
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SAMPLE_O <= '0;
    end else begin
      SAMPLE_O.valid <= valid_q;
      SAMPLE_O.ch1a  <= sat_sample(scaled_a);                  // R11
      SAMPLE_O.ch1b  <= sat_sample(shifted_b);                 // R11
    end
  end

endmodule : dcgv_top

`default_nettype wire

// *** tb/dcgv_asserts.sv ***
/* checker for the gain block ports, bound onto dcgv_top
   assumes one clock and byte register strobes */
`timescale 1ns/1ps
`default_nettype none
module dcgv_asserts (
  input wire logic                       MCLK_I,      // clock
  input wire logic                       RST_N_I,     // reset, low
  input wire dcgv_pkg::dcgv_reg_req_type REG_REQ_I,   // register access
  input wire logic [7:0]                 REG_RDATA_O, // read data
  input wire dcgv_pkg::dcgv_pair_type    SAMPLE_I,    // samples in
  input wire dcgv_pkg::dcgv_pair_type    SAMPLE_O     // samples out
);
  logic [7:0] vol_q;
  logic [3:0] trim_q;
  // mirrors of the two registers, to tie outputs to settings
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      vol_q  <= 8'hC9;
      trim_q <= 4'h8;
    end else if (REG_REQ_I.wr) begin
      if (REG_REQ_I.addr == 8'h69) vol_q <= REG_REQ_I.wdata;
      if (REG_REQ_I.addr == 8'h68) trim_q <= REG_REQ_I.wdata[7:4];
    end
  end
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_rd(a); REG_REQ_I.rd && REG_REQ_I.addr == a; endsequence
  property p_lat; SAMPLE_I.valid |-> ##2 SAMPLE_O.valid; endproperty
  property p_mute; vol_q == 8'h00 |-> ##2 SAMPLE_O.ch1b == 0; endproperty
  property p_unib; vol_q == 8'hC9 |->
    ##2 SAMPLE_O.ch1b == $past(SAMPLE_I.ch1b, 2); endproperty
  property p_unia; trim_q == 4'h8 |->
    ##2 SAMPLE_O.ch1a == $past(SAMPLE_I.ch1a, 2); endproperty
  property p_sat; vol_q == 8'hFF && SAMPLE_I.ch1b == 24'h7FFFFF |->
    ##2 SAMPLE_O.ch1b == 24'h7FFFFF; endproperty
  property p_rvol; s_rd(8'h69) |=> REG_RDATA_O == $past(vol_q); endproperty
  property p_rtrim; s_rd(8'h68) |=>
    REG_RDATA_O == {$past(trim_q), 4'h0}; endproperty
  property p_unmap; REG_REQ_I.rd && REG_REQ_I.addr[7:1] != 7'h34 |=>
    REG_RDATA_O == 8'h00; endproperty
  property p_hold; !REG_REQ_I.rd |=> $stable(REG_RDATA_O); endproperty
  a_lat: assert property (p_lat) else $error("late sample");
  a_mute: assert property (p_mute) else $error("not muted");
  a_unib: assert property (p_unib) else $error("1b not unity");
  a_unia: assert property (p_unia) else $error("1a not unity");
  a_sat: assert property (p_sat) else $error("no saturation");
  a_rvol: assert property (p_rvol) else $error("bad vol read");
  a_rtrim: assert property (p_rtrim) else $error("bad trim read");
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  a_hold: assert property (p_hold) else $error("read data moved");
endmodule : dcgv_asserts
bind dcgv_top dcgv_asserts i_chk (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I),
  .REG_REQ_I(REG_REQ_I), .REG_RDATA_O(REG_RDATA_O),
  .SAMPLE_I(SAMPLE_I), .SAMPLE_O(SAMPLE_O));
`default_nettype wire

// *** tb/tb.sv ***
/* self-checking bench for dcgv_top: registers and gain path
   assumes the checker is bound from its own file */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                       MCLK_I = 1'b0;
  logic                       RST_N_I = 1'b0;
  dcgv_pkg::dcgv_reg_req_type req = '0;
  dcgv_pkg::dcgv_pair_type    si = '0;
  dcgv_pkg::dcgv_pair_type    so;
  logic [7:0]                 rdat;
  int bad_count = 0;
  int checks_done = 0;
  int t;
  int vc[6] = '{1, 2, 201, 202, 254, 255};
  always #5 MCLK_I = ~MCLK_I;
  dcgv_top i_dcgv_top (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .REG_REQ_I(req),
    .REG_RDATA_O(rdat), .SAMPLE_I(si), .SAMPLE_O(so));
  // tolerance covers table rounding and truncation of products
  task automatic chk(input logic [23:0] s, input int e, input int tol);
    int d;
    d = int'($signed(s)) - e;
    checks_done++;
    if ($isunknown(s) || d > tol || -d > tol) begin
      bad_count++;
      $display("unexpected at %0t: got %0d want %0d", $time, $signed(s), e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge MCLK_I) req = {2'b10, a, d};
    @(negedge MCLK_I) req = '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input int e);
    @(negedge MCLK_I) req = {2'b01, a, 8'h00};
    @(negedge MCLK_I) req = '0;
    chk({16'h0000, rdat}, e, 0);
  endtask : rd
  // one pair in, read two edges after the taking edge
  task automatic smp(input logic [23:0] a, input logic [23:0] b);
    @(negedge MCLK_I) si = {1'b1, a, b};
    @(negedge MCLK_I) si.valid = 1'b0;
    repeat (2) @(negedge MCLK_I);
  endtask : smp
  function automatic int ex(input real x, input real db);
    return $rtoi(x * 10.0 ** (db / 20.0));
  endfunction : ex
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  // watchdog far beyond the roughly 190 cycles the tests need
  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end
  initial begin
    repeat (2) @(negedge MCLK_I);
    RST_N_I = 1'b1;
    rd(8'h68, 8'h80);
    rd(8'h69, 8'hC9);
    rd(8'h6A, 0);
    for (int c = 0; c < 16; c++) begin
      wr(8'h68, {c[3:0], 4'h0});
      rd(8'h68, c * 16);
      smp(24'h400000, 24'h400000);
      chk(so.ch1a, ex(4194304.0, (c - 8) * 0.1), 700);
      chk(so.ch1b, 4194304, 0);
    end
    wr(8'h68, 8'h80);
    foreach (vc[i]) begin
      wr(8'h69, vc[i][7:0]);
      smp(24'h000000, 24'h040000);
      t = ex(262144.0, (vc[i] - 201) * 0.5);
      chk(so.ch1b, t, t / 16 + 2);
    end
    wr(8'h69, 8'h00);
    smp(24'h7FFFFF, 24'h7FFFFF);
    chk(so.ch1b, 0, 0);
    chk(so.ch1a, 8388607, 0);
    wr(8'h69, 8'hFF);
    rd(8'h69, 8'hFF);
    smp(24'h000000, 24'h7FFFFF);
    chk(so.ch1b, 8388607, 0);
    smp(24'h000000, 24'h800000);
    chk(so.ch1b, -8388608, 0);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
